/* verilog/mrx_pkg.sv */
// package: register map, fields and types of the mac control/status block
package mrx_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_HASH0   = 8'h50;
	localparam logic [7:0] OFS_HASH1   = 8'h54;
	localparam logic [7:0] OFS_HASH2   = 8'h58;
	localparam logic [7:0] OFS_HASH3   = 8'h5c;
	localparam logic [7:0] OFS_RXCTL   = 8'h60;
	localparam logic [7:0] OFS_RXSTAT  = 8'h64;
	localparam logic [7:0] OFS_RXCNT   = 8'h68;
	localparam logic [7:0] OFS_RXTEST  = 8'h6c;
	localparam logic [7:0] OFS_TXCTL   = 8'h70;
	localparam logic [7:0] OFS_TXSTAT  = 8'h74;
	localparam logic [7:0] OFS_TXPTR   = 8'h78;
	localparam logic [7:0] OFS_TXTEST  = 8'h7c;
	localparam logic [7:0] OFS_RXFIRST = 8'h80;
	localparam logic [7:0] OFS_RXCUR   = 8'h84;
	localparam logic [7:0] OFS_RXHOST  = 8'h88;

	// receive control bits
	localparam int RC_SAVE_ERR  = 0;
	localparam int RC_RUNT      = 1;
	localparam int RC_BCAST     = 2;
	localparam int RC_MCAST     = 3;
	localparam int RC_INVERSE   = 4;
	localparam int RC_PROMISC   = 5;
	localparam int RC_MONITOR   = 6;
	localparam int RC_EARLY     = 7;
	localparam int RC_EXTBUF_LO = 8;

	// receive status bits
	localparam int RS_INTACT  = 0;
	localparam int RS_ALIGN   = 1;
	localparam int RS_CRC     = 2;
	localparam int RS_MISSED  = 3;
	localparam int RS_MCAST   = 4;
	localparam int RS_BCAST   = 5;
	localparam int RS_DISABLE = 6;

	// transmit status bits
	localparam int TS_DONE    = 0;
	localparam int TS_NODEFER = 1;
	localparam int TS_COLL    = 2;
	localparam int TS_CRSLOST = 3;
	localparam int TS_UNDER   = 4;
	localparam int TS_HBEAT   = 5;
	localparam int TS_LATE    = 6;
	localparam int TS_CCNT_LO = 8;
	localparam int TS_CCNT_HI = 12;

	// reset values and timing
	localparam logic [7:0]  TXCTL_RESET  = 8'h78;
	localparam logic [4:0]  SLOT_RESET   = 5'h0f;
	localparam logic [15:0] SLOT_UNIT    = 16'h0020;
	localparam logic [15:0] HBEAT_BITS   = 16'h0024;
	localparam logic [4:0]  COLL_MAX     = 5'h10;
	localparam logic [15:0] MIN_FRAME    = 16'h0040;
	localparam logic [31:0] CRC_GOOD     = 32'hc704dd7b;
	localparam logic [1:0]  LB_FULL      = 2'h3;
	localparam logic [1:0]  LB_INTERNAL  = 2'h1;

	// register bus request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} mrx_req_t;

	// per-frame receive summary, crossed from the link domain
	typedef struct packed {
		logic [15:0] bytes;
		logic        crc_bad;
		logic        odd_nib;
		logic        bcast;
		logic        mcast_hit;
		logic        ind_match;
		logic        ind;
	} mrx_rxsum_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_DATA = 3'b010,
		RX_DONE = 3'b100
	} mrx_rxst_t;

endpackage : mrx_pkg

/* verilog/mrx_core.sv */
// mac receive/transmit control and status with register port
// Function
// - four 16-bit hash registers hold the 64-bit multicast table, low word first
// - external buffer size field is caught from jumpers after reset
// - monitor mode stops buffering, status still updates, no error interrupt
// - promiscuous accepts every individually addressed frame
// - inverse option accepts individual frames not matching station address
// - bit 3 accepts hash-passing multicast, bit 2 accepts broadcast
// - bit 1 accepts runts, otherwise runts are rejected
// - bit 0 keeps frames with crc or alignment errors
// - receive status clears at frame start except disabled; low 7 form stamp
// - missed set when good matched frame not buffered (monitor or overflow)
// - crc error on mismatch or rx error, never runt; alignment if odd with crc error
// - 16-bit byte count of last frame, cleared at each frame start
// - receive fifo level read as 5 bits in test register
// - slot time is (field+1)*32 bit times, reset 0fh, for late collisions and runts
// - loopback field picks normal, internal, external or full duplex
// - transmit control bit 0 selects early transmit
// - transmit status clears per frame; collisions counted in bits 12:8
// - collision later than one slot aborts and sets late flag
// - heartbeat set in transmit, cleared on collision within 36 bits after
// - carrier lost flagged without abort; underrun when dma starves
// - bit 2 for ordinary collisions; bit 1 non-deferred; bit 0 no abort
// - writing current descriptor pointer also loads first; bits 1:0 zero
// - host pointer upper 30 bits address, increment per dword; low 2 offset
// - station address 48 bits in three 16-bit words from eeprom
`timescale 1ns/100ps
module mrx_core
	import mrx_pkg::*;
(
	// system
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// register port
	input  wire mrx_req_t    reg_req,
	output logic [31:0]      reg_rdata,
	// straps and station address
	input  wire logic [1:0]  ext_buf_jumper,
	input  wire logic [47:0] station_addr,
	// buffer and dma side
	input  wire logic        rx_buf_overflow,
	input  wire logic [4:0]  rx_fifo_level,
	input  wire logic        host_dword_written,
	output logic [29:0]      host_dword_addr,
	output logic             rx_buffer_we,
	output logic [6:0]       rx_stamp,
	output logic             rx_err_irq,
	// transmit engine events
	input  wire logic        tx_start,
	input  wire logic        tx_end,
	input  wire logic        tx_collision,
	input  wire logic        tx_carrier,
	input  wire logic        tx_underrun,
	input  wire logic        tx_deferred,
	output logic             tx_abort,
	output logic             tx_early,
	output logic             mii_loop_ext,
	// mii receive link
	input  wire logic        rx_clk,
	input  wire logic        mii_rx_dv,
	input  wire logic        mii_rx_er,
	input  wire logic [3:0]  mii_rxd
);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [15:0] hash_q [4];
	logic [9:0]  rx_ctl_q;
	logic [6:0]  rx_stat_q;
	logic [15:0] rx_cnt_q;
	logic [7:0]  tx_ctl_q;
	logic [12:0] tx_stat_q;
	logic [8:0]  tx_ptr_q;
	logic [7:0]  tx_test_q;
	logic [29:0] rx_first_q;
	logic [29:0] rx_cur_q;
	logic [31:0] rx_host_q;
	logic        strap_done_q;
	logic [63:0] hash_tab;
	logic [15:0] slot_bits;
	logic        full_dup;

	assign hash_tab = {hash_q[3], hash_q[2], hash_q[1], hash_q[0]};
	assign slot_bits = 16'({11'h0, tx_ctl_q[7:3]} + 16'h1) * SLOT_UNIT;
	assign full_dup = tx_ctl_q[2:1] == LB_FULL;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_hash
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					hash_q[gi] <= 16'h0;
				else if (reg_req.wr && reg_req.addr == OFS_HASH0 + 8'(gi * 4))
					hash_q[gi] <= reg_req.wdata[15:0];
			end
		end
	endgenerate

	// jumpers caught on first clock after reset, not under reset itself
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_ctl_q     <= 10'h0;
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
			if (!strap_done_q)
				rx_ctl_q[9:8] <= ext_buf_jumper;
			if (reg_req.wr && reg_req.addr == OFS_RXCTL)
				rx_ctl_q[7:0] <= reg_req.wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_ctl_q  <= TXCTL_RESET;
			tx_ptr_q  <= 9'h0;
			tx_test_q <= 8'h0;
		end else if (reg_req.wr) begin
			if (reg_req.addr == OFS_TXCTL)
				tx_ctl_q <= reg_req.wdata[7:0];
			if (reg_req.addr == OFS_TXPTR)
				tx_ptr_q <= reg_req.wdata[8:0];
			if (reg_req.addr == OFS_TXTEST)
				tx_test_q <= reg_req.wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_first_q <= 30'h0;
			rx_cur_q   <= 30'h0;
			rx_host_q  <= 32'h0;
		end else begin
			if (reg_req.wr && reg_req.addr == OFS_RXCUR) begin
				rx_cur_q   <= reg_req.wdata[31:2];
				rx_first_q <= reg_req.wdata[31:2];
			end else if (reg_req.wr && reg_req.addr == OFS_RXFIRST)
				rx_first_q <= reg_req.wdata[31:2];
			if (reg_req.wr && reg_req.addr == OFS_RXHOST)
				rx_host_q <= reg_req.wdata;
			else if (host_dword_written)
				rx_host_q[31:2] <= rx_host_q[31:2] + 30'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: nibble collection, crc, address capture
	logic        dv_q, er_q;
	logic [3:0]  rxd_q;
	mrx_rxst_t   rst_q;
	logic [31:0] crc_q;
	logic [16:0] nib_q;
	logic [47:0] da_q;
	logic        er_seen_q;
	mrx_rxsum_t  sum_q;
	logic        start_tgl_q, end_tgl_q;
	logic [31:0] crc_nx;

	always_comb begin
		crc_nx = crc_q;
		for (int b = 0; b < 4; b++)
			crc_nx = {crc_nx[30:0], 1'b0}
				^ ((crc_nx[31] ^ rxd_q[b]) ? 32'h04c11db7 : 32'h0);
	end

	// pins sampled once on rx_clk, the phy's own timing reference
	always_ff @(posedge rx_clk or negedge rst_n) begin
		if (!rst_n) begin
			dv_q  <= 1'b0;
			er_q  <= 1'b0;
			rxd_q <= 4'h0;
		end else begin
			dv_q  <= mii_rx_dv;
			er_q  <= mii_rx_er;
			rxd_q <= mii_rxd;
		end
	end

	always_ff @(posedge rx_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q       <= RX_IDLE;
			crc_q       <= 32'hffffffff;
			nib_q       <= 17'h0;
			da_q        <= 48'h0;
			er_seen_q   <= 1'b0;
			sum_q       <= '0;
			start_tgl_q <= 1'b0;
			end_tgl_q   <= 1'b0;
		end else begin
			case (rst_q)
			RX_IDLE: begin
				crc_q     <= 32'hffffffff;
				nib_q     <= 17'h0;
				er_seen_q <= 1'b0;
				if (dv_q && rxd_q == 4'hd) begin
					rst_q       <= RX_DATA;
					start_tgl_q <= ~start_tgl_q;
				end
			end
			RX_DATA: begin
				if (dv_q) begin
					crc_q <= crc_nx;
					nib_q <= nib_q + 17'h1;
					if (er_q)
						er_seen_q <= 1'b1;
					if (nib_q < 17'd12)
						da_q[6'(nib_q) * 4 +: 4] <= rxd_q;
				end else
					rst_q <= RX_DONE;
			end
			RX_DONE: begin
				sum_q.bytes     <= nib_q[16:1];
				sum_q.odd_nib   <= nib_q[0];
				sum_q.crc_bad   <= crc_q != CRC_GOOD || er_seen_q;
				sum_q.bcast     <= &da_q;
				sum_q.ind       <= !da_q[0];
				sum_q.ind_match <= da_q == station_addr;
				sum_q.mcast_hit <= da_q[0] && hash_tab[da_crc6(da_q)];
				end_tgl_q       <= ~end_tgl_q;
				rst_q           <= RX_IDLE;
			end
			default: rst_q <= RX_IDLE;
			endcase
		end
	end

	// hash index: top six bits of crc over destination
	function automatic logic [5:0] da_crc6(input logic [47:0] da);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? 32'h04c11db7 : 32'h0);
		return c[31:26];
	endfunction : da_crc6

	////////////////////////////////////////////////////////////////////////
	// crossing: toggles through three flops; summary stable a frame long
	logic [2:0] st_sync_q, en_sync_q;
	logic       frame_start, frame_end;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_sync_q <= 3'h0;
			en_sync_q <= 3'h0;
		end else begin
			st_sync_q <= {st_sync_q[1:0], start_tgl_q};
			en_sync_q <= {en_sync_q[1:0], end_tgl_q};
		end
	end
	assign frame_start = st_sync_q[2] ^ st_sync_q[1];
	assign frame_end   = en_sync_q[2] ^ en_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// receive accept and status
	logic runt, accept, errd, keep;

	assign runt   = {sum_q.bytes, 3'h0} < {3'h0, slot_bits};
	assign errd   = sum_q.crc_bad && !runt;
	assign accept = (sum_q.ind && (rx_ctl_q[RC_PROMISC]
			|| (sum_q.ind_match ^ rx_ctl_q[RC_INVERSE])))
		|| (sum_q.bcast && rx_ctl_q[RC_BCAST])
		|| (!sum_q.bcast && !sum_q.ind && sum_q.mcast_hit
			&& rx_ctl_q[RC_MCAST]);
	assign keep   = accept && (!runt || rx_ctl_q[RC_RUNT])
		&& (!errd || rx_ctl_q[RC_SAVE_ERR]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_stat_q    <= 7'h0;
			rx_cnt_q     <= 16'h0;
			rx_buffer_we <= 1'b0;
			rx_err_irq   <= 1'b0;
			rx_stamp     <= 7'h0;
		end else begin
			rx_buffer_we <= 1'b0;
			rx_err_irq   <= 1'b0;
			rx_stat_q[RS_DISABLE] <= rx_ctl_q[RC_MONITOR];
			if (frame_start) begin
				rx_stat_q[5:0] <= 6'h0;
				rx_cnt_q       <= 16'h0;
			end else if (frame_end) begin
				rx_cnt_q <= sum_q.bytes;
				rx_stat_q[RS_CRC]   <= errd;
				rx_stat_q[RS_ALIGN] <= errd && sum_q.odd_nib;
				rx_stat_q[RS_BCAST] <= sum_q.bcast && accept;
				rx_stat_q[RS_MCAST] <= sum_q.mcast_hit && accept;
				rx_stat_q[RS_MISSED] <= keep && !errd
					&& (rx_ctl_q[RC_MONITOR] || rx_buf_overflow);
				rx_stat_q[RS_INTACT] <= keep && !errd
					&& !rx_ctl_q[RC_MONITOR] && !rx_buf_overflow;
				rx_buffer_we <= keep && !rx_ctl_q[RC_MONITOR]
					&& !rx_buf_overflow;
				rx_err_irq <= errd && !rx_ctl_q[RC_MONITOR];
				// stamp mirrors the status bits written at this same edge
				rx_stamp <= {rx_ctl_q[RC_MONITOR],
					sum_q.bcast && accept, sum_q.mcast_hit && accept,
					keep && !errd && (rx_ctl_q[RC_MONITOR]
					|| rx_buf_overflow), errd, errd && sum_q.odd_nib,
					keep && !errd && !rx_ctl_q[RC_MONITOR]
					&& !rx_buf_overflow};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit status, counted in system clocks at 100 Mb/s nibble rate
	logic [15:0] tx_bits_q;
	logic [15:0] hb_q;
	logic        tx_act_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_stat_q <= 13'h0;
			tx_bits_q <= 16'h0;
			hb_q      <= 16'h0;
			tx_act_q  <= 1'b0;
			tx_abort  <= 1'b0;
		end else begin
			tx_abort <= 1'b0;
			if (hb_q != 16'h0)
				hb_q <= hb_q - 16'h4;
			if (tx_start) begin
				tx_stat_q <= 13'h0;
				tx_stat_q[TS_HBEAT] <= !full_dup;
				tx_stat_q[TS_NODEFER] <= !tx_deferred;
				tx_bits_q <= 16'h0;
				tx_act_q  <= 1'b1;
			end else if (tx_act_q) begin
				tx_bits_q <= tx_bits_q + 16'h4;
				if (tx_underrun)
					tx_stat_q[TS_UNDER] <= 1'b1;
				if (!tx_carrier && !full_dup)
					tx_stat_q[TS_CRSLOST] <= 1'b1;
				if ((tx_collision || tx_test_q[7]) && !full_dup) begin
					if (tx_bits_q > slot_bits) begin
						tx_stat_q[TS_LATE] <= 1'b1;
						tx_abort <= 1'b1;
						tx_act_q <= 1'b0;
					end else begin
						tx_stat_q[12:8] <= tx_stat_q[12:8] + 5'h1;
						if (tx_stat_q[12:8] + 5'h1 == COLL_MAX) begin
							tx_abort <= 1'b1;
							tx_act_q <= 1'b0;
							tx_stat_q[TS_COLL] <= 1'b0;
						end else
							tx_stat_q[TS_COLL] <= 1'b1;
					end
				end else if (tx_end) begin
					tx_act_q <= 1'b0;
					tx_stat_q[TS_DONE] <= 1'b1;
					hb_q <= HBEAT_BITS;
				end
			end else if (hb_q != 16'h0 && tx_collision && !full_dup)
				tx_stat_q[TS_HBEAT] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read mux, outputs registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata       <= 32'h0;
			host_dword_addr <= 30'h0;
			tx_early        <= 1'b0;
			mii_loop_ext    <= 1'b0;
		end else begin
			host_dword_addr <= rx_host_q[31:2];
			tx_early        <= tx_ctl_q[0];
			mii_loop_ext    <= tx_ctl_q[2:1] == 2'h2;
			if (reg_req.rd) begin
				case (reg_req.addr)
				OFS_HASH0:   reg_rdata <= {16'h0, hash_q[0]};
				OFS_HASH1:   reg_rdata <= {16'h0, hash_q[1]};
				OFS_HASH2:   reg_rdata <= {16'h0, hash_q[2]};
				OFS_HASH3:   reg_rdata <= {16'h0, hash_q[3]};
				OFS_RXCTL:   reg_rdata <= {22'h0, rx_ctl_q};
				OFS_RXSTAT:  reg_rdata <= {25'h0, rx_stat_q};
				OFS_RXCNT:   reg_rdata <= {16'h0, rx_cnt_q};
				OFS_RXTEST:  reg_rdata <= {17'h0, rx_fifo_level, 10'h0};
				OFS_TXCTL:   reg_rdata <= {24'h0, tx_ctl_q};
				OFS_TXSTAT:  reg_rdata <= {19'h0, tx_stat_q};
				OFS_TXTEST:  reg_rdata <= {24'h0, tx_test_q};
				OFS_RXFIRST: reg_rdata <= {rx_first_q, 2'h0};
				OFS_RXCUR:   reg_rdata <= {rx_cur_q, 2'h0};
				OFS_RXHOST:  reg_rdata <= rx_host_q;
				default:     reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_cur_write;
		reg_req.wr && reg_req.addr == OFS_RXCUR;
	endsequence

	property p_ptr_pair;
		@(posedge clk_sys) disable iff (!rst_n)
		s_cur_write |=> rx_first_q == rx_cur_q;
	endproperty
	a_ptr_pair: assert property (p_ptr_pair)
		else $error("first pointer not loaded with current");

	property p_start_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		frame_start |=> rx_stat_q[5:0] == 6'h0 && rx_cnt_q == 16'h0;
	endproperty
	a_start_clear: assert property (p_start_clear)
		else $error("receive status not cleared at start");

	property p_stamp_status;
		@(posedge clk_sys) disable iff (!rst_n)
		frame_end |=> rx_stamp[5:0] == rx_stat_q[5:0];
	endproperty
	a_stamp_status: assert property (p_stamp_status)
		else $error("frame stamp differs from status");

	property p_monitor_nobuf;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_ctl_q[RC_MONITOR] && frame_end |=> !rx_buffer_we && !rx_err_irq;
	endproperty
	a_monitor_nobuf: assert property (p_monitor_nobuf)
		else $error("frame buffered in monitor mode");

	property p_align_needs_crc;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_stat_q[RS_ALIGN] |-> rx_stat_q[RS_CRC];
	endproperty
	a_align_needs_crc: assert property (p_align_needs_crc)
		else $error("alignment error without crc error");

	property p_slot_reset;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_ctl_q[7:3] == SLOT_RESET |-> slot_bits == 16'd512;
	endproperty
	a_slot_reset: assert property (p_slot_reset)
		else $error("slot time wrong");

	property p_fd_quiet;
		@(posedge clk_sys) disable iff (!rst_n)
		full_dup && tx_start |=> !tx_stat_q[TS_HBEAT];
	endproperty
	a_fd_quiet: assert property (p_fd_quiet)
		else $error("heartbeat set in full duplex");

	property p_tx_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_start |=> tx_stat_q[12:8] == 5'h0 && !tx_stat_q[TS_LATE];
	endproperty
	a_tx_clear: assert property (p_tx_clear)
		else $error("transmit status not cleared");

	property p_late_abort;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_act_q && !tx_start && tx_collision && !full_dup
			&& tx_bits_q > slot_bits |=> tx_abort && tx_stat_q[TS_LATE];
	endproperty
	a_late_abort: assert property (p_late_abort)
		else $error("late collision not aborted");

	property p_host_inc;
		@(posedge clk_sys) disable iff (!rst_n)
		host_dword_written && !reg_req.wr |=>
			rx_host_q[31:2] == $past(rx_host_q[31:2]) + 30'h1;
	endproperty
	a_host_inc: assert property (p_host_inc)
		else $error("host pointer did not advance");

endmodule : mrx_core

/* bench/mrx_phy_model.sv */
// phy model: sends mii receive frames on a gated link clock
`timescale 1ns/100ps
module mrx_phy_model (
	// mii receive link
	output logic       rx_clk,
	output logic       mii_rx_dv,
	output logic       mii_rx_er,
	output logic [3:0] mii_rxd
);
	initial begin
		rx_clk    = 1'b0;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		mii_rxd   = 4'h0;
	end
	////////////////////////////////////////////////////////////////////
	// clock runs only while sending and for three ticks at reset; idle data flips so stale is seen
	task automatic tick(input int n);
		repeat (n) begin
			#40 rx_clk = 1'b1;
			#40 rx_clk = 1'b0;
			mii_rxd = mii_rx_dv ? mii_rxd : ~mii_rxd;
		end
	endtask : tick
	// preamble, start nibble, bytes low nibble first, optional odd nibble
	task automatic send(input logic [7:0] fb [0:67], input int len,
			input logic odd, input logic er);
		logic [3:0] nb [0:153];
		int         n;
		for (n = 0; n < 15; n++)
			nb[n] = 4'h5;
		nb[15] = 4'hd;
		for (int i = 0; i < len; i++) begin
			nb[16+2*i] = fb[i][3:0];
			nb[17+2*i] = fb[i][7:4];
		end
		nb[16+2*len] = 4'h3;
		n = 16 + 2 * len + int'(odd);
		for (int i = 0; i < n; i++) begin
			mii_rx_dv = 1'b1;
			mii_rx_er = er && i == 40;
			mii_rxd   = nb[i];
			tick(1);
		end
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		tick(6);
	endtask : send
endmodule : mrx_phy_model

/* bench/tb_mac_rx_tx_control_status.sv */
// testbench: registers, receive filtering and transmit status
`timescale 1ns/100ps
module tb_mac_rx_tx_control_status;
	import mrx_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n, rx_buf_overflow, host_dword_written;
	mrx_req_t    reg_req;
	logic [31:0] reg_rdata;
	logic [29:0] host_dword_addr;
	logic [6:0]  rx_stamp;
	logic [47:0] station_addr;
	logic [1:0]  ext_buf_jumper;
	logic [4:0]  rx_fifo_level;
	logic        rx_buffer_we, rx_err_irq, tx_abort, tx_early, mii_loop_ext;
	logic        tx_start, tx_end, tx_collision, tx_carrier;
	logic        tx_underrun, tx_deferred;
	logic        rx_clk, mii_rx_dv, mii_rx_er;
	logic [3:0]  mii_rxd;
	int          err_total, cmp_count, we_n, irq_n, ab_n;

	mrx_core dut (.clk_sys, .rst_n, .reg_req, .reg_rdata, .ext_buf_jumper,
		.station_addr, .rx_buf_overflow, .rx_fifo_level,
		.host_dword_written, .host_dword_addr, .rx_buffer_we, .rx_stamp,
		.rx_err_irq, .tx_start, .tx_end, .tx_collision, .tx_carrier,
		.tx_underrun, .tx_deferred, .tx_abort, .tx_early, .mii_loop_ext,
		.rx_clk, .mii_rx_dv, .mii_rx_er, .mii_rxd);
	mrx_phy_model phy (.rx_clk, .mii_rx_dv, .mii_rx_er, .mii_rxd);

	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		we_n  += int'(rx_buffer_we === 1'b1);
		irq_n += int'(rx_err_irq === 1'b1);
		ab_n  += int'(tx_abort === 1'b1);
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp, msk);
		cmp_count++;
		if (((got ^ exp) & msk) !== 32'h0) begin
			err_total++;
			$display("ERROR t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge clk_sys);
		reg_req <= '0;
	endtask : wr
	// read holds until the next read, so one spare edge is harmless
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		@(posedge clk_sys);
		reg_req <= '{1'b1, 1'b0, a, 32'h0};
		@(posedge clk_sys);
		reg_req <= '0;
		@(posedge clk_sys);
		#1 chk(reg_rdata, e, m);
	endtask : rd
	// f = {hash ones, bad fcs, odd nibble, rx error, overflow}
	task automatic rxrow(input logic [7:0] ctl, input int dst, len,
			input logic [4:0] f, input logic we, input logic [6:0] st);
		logic [7:0]  fb [0:67];
		logic [47:0] da;
		logic [31:0] c;
		int          w0;
		int          i0;
		da = dst == 0 ? station_addr : dst == 1 ? 48'h4 :
			dst == 2 ? 48'hffff_ffff_ffff : 48'h301;
		for (int i = 0; i < 4; i++)
			wr(OFS_HASH0 + 8'(4 * i), {32{f[4]}});
		wr(OFS_RXCTL, {24'h0, ctl});
		rx_buf_overflow <= f[0];
		c = 32'hffff_ffff;
		for (int i = 0; i < 68; i++) begin
			fb[i] = i < 6 ? da[8*i+:8] : 8'(i);
			if (i < len - 4) begin
				c ^= {24'h0, fb[i]};
				repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
			end
		end
		c = ~c ^ {31'h0, f[3]};
		for (int i = 0; i < 4; i++)
			fb[len-4+i] = c[8*i+:8];
		w0 = we_n;
		i0 = irq_n;
		phy.send(fb, len, f[2], f[1]);
		cyc(12);
		chk(32'(we_n - w0), {31'h0, we}, '1);
		rd(OFS_RXSTAT, {25'h0, st}, 32'h7f);
		rd(OFS_RXCNT, 32'(len), 32'hffff);
		chk({25'h0, rx_stamp}, {25'h0, st}, 32'h7f);
		chk(32'(irq_n - i0), {31'h0, st[2] && !ctl[6]}, '1);
		rx_buf_overflow <= 1'b0;
	endtask : rxrow
	// lead cycles, collisions, end pulse, late heartbeat hit, carrier loss
	task automatic txrun(input int lead, ncol, input logic ende, hb, cl,
			input logic [31:0] e, m);
		tx_start <= 1'b1;
		cyc(1);
		tx_start <= 1'b0;
		cyc(lead);
		tx_carrier <= ~cl;
		tx_underrun <= cl;
		cyc(1);
		tx_underrun <= 1'b0;
		repeat (ncol) begin
			tx_collision <= 1'b1;
			cyc(1);
			tx_collision <= 1'b0;
			cyc(2);
		end
		tx_end <= ende;
		cyc(1);
		tx_end <= 1'b0;
		tx_carrier <= 1'b1;
		// hit three clocks after the end, well inside the 36-bit window
		if (hb) begin
			cyc(2);
			tx_collision <= 1'b1;
			cyc(1);
			tx_collision <= 1'b0;
		end
		cyc(12);
		rd(OFS_TXSTAT, e, m);
	endtask : txrun
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////
	initial begin
		#2ms err_total++;
		complete_run();
	end
	initial begin
		{rst_n, rx_buf_overflow, host_dword_written, tx_start} = 4'h0;
		{tx_end, tx_collision, tx_underrun, tx_deferred} = 4'h0;
		tx_carrier = 1'b1;
		reg_req = '0;
		station_addr = 48'h5544_3322_1102;
		ext_buf_jumper = 2'h2;
		rx_fifo_level = 5'h15;
		{err_total, cmp_count, we_n, irq_n, ab_n} = '0;
		fork
			phy.tick(3);
			cyc(20);
		join
		rst_n <= 1'b1;
		cyc(2);
		rd(OFS_TXCTL, 32'h78, '1);
		rd(OFS_RXSTAT, 32'h0, 32'h7f);
		rd(OFS_RXCTL, 32'h200, 32'h300);
		wr(OFS_RXCTL, 32'h100);
		rd(OFS_RXCTL, 32'h200, 32'h300);
		rd(OFS_RXTEST, 32'h5400, 32'h7c00);
		rd(8'h40, 32'h0, '1);
		for (int i = 0; i < 4; i++)
			wr(OFS_HASH0 + 8'(4 * i), 32'h1230 + 32'(i));
		for (int i = 0; i < 4; i++)
			rd(OFS_HASH0 + 8'(4 * i), 32'h1230 + 32'(i), 32'hffff);
		wr(OFS_TXCTL, 32'h7d);
		cyc(1);
		#1 chk({30'h0, tx_early, mii_loop_ext}, 32'h3, '1);
		wr(OFS_TXCTL, 32'h78);
		cyc(1);
		#1 chk({30'h0, tx_early, mii_loop_ext}, 32'h0, '1);
		wr(OFS_RXCUR, 32'h1234_5677);
		rd(OFS_RXFIRST, 32'h1234_5674, '1);
		rd(OFS_RXCUR, 32'h1234_5674, '1);
		wr(OFS_RXHOST, 32'h1003);
		host_dword_written <= 1'b1;
		cyc(2);
		host_dword_written <= 1'b0;
		cyc(1);
		#1 chk({2'h0, host_dword_addr}, 32'h402, '1);
		rd(OFS_RXHOST, 32'h100b, '1);
		$display("registers done");
		// early receive stays off throughout
		rxrow(8'h00, 0, 64, 5'b00000, 1, 7'h01);
		rxrow(8'h00, 1, 64, 5'b00000, 0, 7'h00);
		rxrow(8'h20, 1, 64, 5'b00000, 1, 7'h01);
		rxrow(8'h10, 1, 64, 5'b00000, 1, 7'h01);
		rxrow(8'h04, 2, 64, 5'b00000, 1, 7'h21);
		rxrow(8'h08, 3, 64, 5'b10000, 1, 7'h11);
		rxrow(8'h08, 3, 64, 5'b00000, 0, 7'h00);
		rxrow(8'h00, 0, 64, 5'b01100, 0, 7'h06);
		rxrow(8'h01, 0, 64, 5'b01000, 1, 7'h04);
		rxrow(8'h01, 0, 64, 5'b00010, 1, 7'h04);
		rxrow(8'h00, 0, 32, 5'b00000, 0, 7'h00);
		rxrow(8'h02, 0, 32, 5'b00000, 1, 7'h01);
		rxrow(8'h00, 0, 32, 5'b01000, 0, 7'h00);
		rxrow(8'h40, 0, 64, 5'b00000, 0, 7'h48);
		rxrow(8'h40, 0, 64, 5'b01000, 0, 7'h44);
		rxrow(8'h00, 0, 64, 5'b00001, 0, 7'h08);
		wr(OFS_TXCTL, 32'h0);
		rxrow(8'h00, 0, 32, 5'b00000, 1, 7'h01);
		$display("receive done");
		wr(OFS_TXCTL, 32'h78);
		txrun(4, 2, 1, 0, 0, 32'h227, 32'h1f7f);
		txrun(4, 0, 1, 1, 0, 32'h1, 32'h21);
		txrun(2, 16, 0, 0, 0, 32'h1000, 32'h1f45);
		tx_deferred <= 1'b1;
		txrun(4, 0, 1, 0, 1, 32'h19, 32'h1f1b);
		tx_deferred <= 1'b0;
		wr(OFS_TXCTL, 32'h7e);
		txrun(4, 0, 1, 0, 1, 32'h11, 32'h38);
		wr(OFS_TXCTL, 32'h08);
		txrun(24, 1, 0, 0, 0, 32'h40, 32'h45);
		chk(32'(ab_n), 32'h2, '1);
		$display("transmit done");
		complete_run();
	end
endmodule : tb_mac_rx_tx_control_status
